// ### lcd_engine_pkg.sv
package lcd_engine_pkg;
  // clock and execution times
  localparam int CLK_NS      = 100;
  localparam int T_LONG_NS   = 1530000;
  localparam int T_SHORT_NS  = 39000;
  localparam int T_DATA_NS   = 43000;
  // "complete within" figures are longest times: round down
  localparam int CYC_LONG    = T_LONG_NS / CLK_NS;
  localparam int CYC_SHORT   = T_SHORT_NS / CLK_NS;
  localparam int CYC_DATA    = T_DATA_NS / CLK_NS;
  localparam int TIMER_W     = 16;

  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] AC_HOME    = 7'h00;
  localparam logic [6:0] AC_STEP    = 7'h01;
  localparam logic [6:0] TEXT_LAST  = 7'h7f;
  localparam logic [6:0] SHIFT_RST  = 7'h00;

  // instruction field positions
  localparam int B_TEXT  = 7;
  localparam int B_GLYPH = 6;
  localparam int B_FUNC  = 5;
  localparam int B_SHIFT = 4;
  localparam int B_DISP  = 3;
  localparam int B_ENTRY = 2;
  localparam int B_HOME  = 1;
  localparam int F_ID    = 1;
  localparam int F_SH    = 0;
  localparam int F_DL    = 4;
  localparam int F_N     = 3;
  localparam int F_F     = 2;
  localparam int F_D     = 2;
  localparam int F_C     = 1;
  localparam int F_B     = 0;
  localparam int F_SC    = 3;
  localparam int F_RL    = 2;

  localparam logic [7:0] OE_BYTE  = 8'hff;
  localparam logic [7:0] OE_UPPER = 8'hf0;
  localparam logic [7:0] OE_NONE  = 8'h00;

  // ahb-lite
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS    = 32'h0000_0004;
  localparam logic [31:0] OFS_MODE      = 32'h0000_0008;
  localparam logic [31:0] OFS_PEEK      = 32'h0000_000c;

  localparam int FIFO_W     = 10;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_WAIT} exec_state_e;
  typedef enum logic [3:0] {OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISP, OP_SHIFT,
                            OP_FUNC, OP_GLYPH, OP_TEXT, OP_WR, OP_RD} op_e;

  function automatic op_e classify(input logic rs, input logic rw, input logic [7:0] b);
    if (rs) return rw ? OP_RD : OP_WR;
    if (b[B_TEXT]) return OP_TEXT;
    if (b[B_GLYPH]) return OP_GLYPH;
    if (b[B_FUNC]) return OP_FUNC;
    if (b[B_SHIFT]) return OP_SHIFT;
    if (b[B_DISP]) return OP_DISP;
    if (b[B_ENTRY]) return OP_ENTRY;
    if (b[B_HOME]) return OP_HOME;
    return OP_CLEAR;
  endfunction

  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up, input logic glyph);
    logic [6:0] n;
    n = up ? a + AC_STEP : a - AC_STEP;
    return glyph ? {1'b0, n[5:0]} : n;
  endfunction
endpackage

// ### lcd_instr_engine.sv
// Functional notes
// - register_select and read/write pick instruction, busy read, data write or data read.
// - clear fills text memory with spaces, homes the counter, within 1.53 ms.
// - return home zeroes counter and display shift, text kept, within 1.53 ms.
// - entry mode latches step direction and shift_on_write, 39 us.
// - display control latches display, cursor and blink bits.
// - cursor/display shift leaves memory alone, 39 us.
// - function set latches bus width, line count and font, 39 us.
// - glyph address set loads 6-bit counter and selects glyph memory, 39 us.
// - text address set loads 7-bit counter and selects text memory, 39 us.
// - busy read returns busy_indicator on bit 7 and counter below, anytime.
// - data write stores the byte in the selected memory, 43 us.
// - data read returns the selected memory byte, 43 us.
// - every data access steps the counter by one up or down.
// - busy high during internal work; host waits for it low.
// - in 4-bit width each byte is two transfers on upper lines.
// - shift target low moves cursor and counter; high shifts the display.
// - text write with shift_on_write shifts the display per direction.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
module lcd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             hclk,      // clock
  input  wire logic             hresetn,   // async reset, low
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room left
  input  wire logic [WIDTH-1:0] in_data,   // pushed word
  output logic                  out_valid, // word waiting
  input  wire logic             out_ready, // pop request
  output logic [WIDTH-1:0]      out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             full;
  logic             empty;

  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty     = (wr_q == rd_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (in_valid && !full) wr_d = wr_q + 1'b1;
    if (out_ready && !empty) rd_d = rd_q + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge hclk) begin
    if (in_valid && !full) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

module lcd_instr_engine #(
  parameter int unsigned CLEAR_CYCLES = lcd_engine_pkg::CYC_LONG
) (
  input  wire logic        hclk,            // 10 MHz clock
  input  wire logic        hresetn,         // async reset, low
  input  wire logic        hsel,            // ahb select
  input  wire logic [31:0] haddr,           // ahb address
  input  wire logic [1:0]  htrans,          // ahb transfer type
  input  wire logic        hwrite,          // ahb write
  input  wire logic [2:0]  hsize,           // ahb size
  input  wire logic [31:0] hwdata,          // ahb write data
  input  wire logic        hready,          // ahb bus ready
  output logic             hreadyout,       // never stalls
  output logic             hresp,           // always okay
  output logic [31:0]      hrdata,          // ahb read data
  input  wire logic        register_select, // pin: data vs instruction
  input  wire logic        rw_sel,          // pin: high reads
  input  wire logic        strobe_en,       // pin: enable strobe
  input  wire logic [7:0]  db_in,           // pin: data bus in
  output logic [7:0]       db_out,          // pin: data bus out
  output logic [7:0]       db_oe            // pin: per-line drive enable
);
  import lcd_engine_pkg::*;

  // pin synchronisers, first stage read only by second
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic        en_s3_q;
  logic        rs_s;
  logic        rw_s;
  logic        en_s;
  logic [7:0]  db_s;
  logic        rise;
  logic        fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      en_s3_q  <= 1'b0;
    end else begin
      pin_s1_q <= {register_select, rw_sel, strobe_en, db_in};
      pin_s2_q <= pin_s1_q;
      en_s3_q  <= pin_s2_q[8];
    end
  end

  assign rs_s = pin_s2_q[10];
  assign rw_s = pin_s2_q[9];
  assign en_s = pin_s2_q[8];
  assign db_s = pin_s2_q[7:0];
  assign rise = en_s && !en_s3_q;
  assign fall = !en_s && en_s3_q;

  // engine state
  exec_state_e        st_q, st_d;
  logic [TIMER_W-1:0] tmr_q, tmr_d;
  logic [6:0]         ac_q, ac_d;
  logic [6:0]         clr_idx_q, clr_idx_d;
  logic [6:0]         shift_q, shift_d;
  logic [7:0]         dhr_q, dhr_d;
  logic               glyph_q, glyph_d;
  logic               incr_q, incr_d;
  logic               sow_q, sow_d;
  logic               disp_q, disp_d;
  logic               cur_q, cur_d;
  logic               blink_q, blink_d;
  logic               width8_q, width8_d;
  logic               lines_q, lines_d;
  logic               font_q, font_d;
  logic [7:0]         text_mem [128];
  logic [7:0]         glyph_mem [64];
  logic               txt_we;
  logic               glf_we;
  logic [6:0]         mem_addr;
  logic [7:0]         mem_data;

  // front end and software state
  logic        low_phase_q, low_phase_d;
  logic [3:0]  hi_nib_q, hi_nib_d;
  logic [7:0]  db_out_q, db_out_d;
  logic        oe_q, oe_d;
  logic        accept_q, accept_d;
  logic [6:0]  peek_q, peek_d;
  logic        wr_pend_q, wr_pend_d;
  logic [31:0] wa_q, wa_d;
  logic [31:0] rdata_q, rdata_d;

  // fifo
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic [FIFO_W-1:0]   fifo_in_data;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [FIFO_W-1:0]   fifo_out_data;
  logic                e_rs;
  logic                e_rw;
  logic [7:0]          e_byte;
  op_e                 op;
  logic                pop;
  logic                busy;
  logic [7:0]          rd_byte;

  function automatic logic [TIMER_W-1:0] exec_cycles(input op_e o);
    case (o)
      OP_CLEAR, OP_HOME: return TIMER_W'(CLEAR_CYCLES);
      OP_WR, OP_RD:      return TIMER_W'(CYC_DATA);
      default:           return TIMER_W'(CYC_SHORT);
    endcase
  endfunction

  // a word still queued counts as internal work
  assign busy = (st_q != ST_IDLE) || fifo_out_valid;
  assign rd_byte = rs_s ? dhr_q : {busy, ac_q};

  // busy/address reads are served at once and never queued
  assign fifo_in_valid = fall && accept_q && !(!rs_s && rw_s) && (width8_q || low_phase_q);
  assign fifo_in_data  = {rs_s, rw_s, width8_q ? db_s : {hi_nib_q, db_s[7:4]}};

  lcd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) lcd_fifo_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign e_rs           = fifo_out_data[9];
  assign e_rw           = fifo_out_data[8];
  assign e_byte         = fifo_out_data[7:0];
  assign op             = classify(e_rs, e_rw, e_byte);
  assign fifo_out_ready = (st_q == ST_IDLE);
  assign pop            = fifo_out_valid && fifo_out_ready;

  always_comb begin
    low_phase_d = low_phase_q;
    hi_nib_d    = hi_nib_q;
    db_out_d    = db_out_q;
    oe_d        = oe_q;
    if (rise && rw_s && accept_q) begin
      oe_d = 1'b1;
      if (width8_q) db_out_d = rd_byte;
      else db_out_d = low_phase_q ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
    end
    if (fall) oe_d = 1'b0;
    if (fall && accept_q && !width8_q) begin
      low_phase_d = !low_phase_q;
      if (!low_phase_q) hi_nib_d = db_s[7:4];
    end
  end

  always_comb begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    ac_d      = ac_q;
    clr_idx_d = clr_idx_q;
    shift_d   = shift_q;
    dhr_d     = dhr_q;
    glyph_d   = glyph_q;
    incr_d    = incr_q;
    sow_d     = sow_q;
    disp_d    = disp_q;
    cur_d     = cur_q;
    blink_d   = blink_q;
    width8_d  = width8_q;
    lines_d   = lines_q;
    font_d    = font_q;
    txt_we    = 1'b0;
    glf_we    = 1'b0;
    mem_addr  = ac_q;
    mem_data  = e_byte;
    case (st_q)
      ST_IDLE: begin
        if (pop) begin
          tmr_d = exec_cycles(op) - 1'b1;
          st_d  = ST_WAIT;
          case (op)
            OP_CLEAR: begin
              ac_d      = AC_HOME;
              glyph_d   = 1'b0;
              incr_d    = 1'b1;
              shift_d   = SHIFT_RST;
              clr_idx_d = AC_HOME;
              st_d      = ST_CLEAR;
            end
            OP_HOME: begin
              ac_d    = AC_HOME;
              glyph_d = 1'b0;
              shift_d = SHIFT_RST;
            end
            OP_ENTRY: begin
              incr_d = e_byte[F_ID];
              sow_d  = e_byte[F_SH];
            end
            OP_DISP: begin
              disp_d  = e_byte[F_D];
              cur_d   = e_byte[F_C];
              blink_d = e_byte[F_B];
            end
            OP_SHIFT: begin
              if (e_byte[F_SC]) shift_d = e_byte[F_RL] ? shift_q - AC_STEP : shift_q + AC_STEP;
              else ac_d = ac_step(ac_q, e_byte[F_RL], glyph_q);
            end
            OP_FUNC: begin
              width8_d = e_byte[F_DL];
              lines_d  = e_byte[F_N];
              font_d   = e_byte[F_F];
            end
            OP_GLYPH: begin
              ac_d    = {1'b0, e_byte[5:0]};
              glyph_d = 1'b1;
            end
            OP_TEXT: begin
              ac_d    = e_byte[6:0];
              glyph_d = 1'b0;
            end
            OP_WR: begin
              if (glyph_q) glf_we = 1'b1;
              else begin
                txt_we = 1'b1;
                if (sow_q) shift_d = incr_q ? shift_q + AC_STEP : shift_q - AC_STEP;
              end
              ac_d = ac_step(ac_q, incr_q, glyph_q);
            end
            OP_RD: ac_d = ac_step(ac_q, incr_q, glyph_q);
            default: ;
          endcase
        end
      end
      ST_CLEAR: begin
        txt_we    = 1'b1;
        mem_addr  = clr_idx_q;
        mem_data  = SPACE_CODE;
        clr_idx_d = clr_idx_q + AC_STEP;
        tmr_d     = tmr_q - 1'b1;
        if (clr_idx_q == TEXT_LAST) st_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (tmr_q == '0) begin
          st_d  = ST_IDLE;
          // prefetch so the next data read sees the new location
          dhr_d = glyph_q ? glyph_mem[ac_q[5:0]] : text_mem[ac_q];
        end else tmr_d = tmr_q - 1'b1;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ahb-lite slave, zero wait states
  always_comb begin
    wr_pend_d = 1'b0;
    wa_d      = wa_q;
    rdata_d   = '0;
    accept_d  = accept_q;
    peek_d    = peek_q;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      wr_pend_d = hwrite && (hsize == HSIZE_WORD);
      wa_d      = haddr;
      if (!hwrite) begin
        case (haddr)
          OFS_CTRL:   rdata_d = {31'h0, accept_q};
          OFS_STATUS: rdata_d = {21'h0, !fifo_in_ready, fifo_out_valid, glyph_q, busy, ac_q};
          OFS_MODE:   rdata_d = {17'h0, shift_q, disp_q, cur_q, blink_q, width8_q,
                                 lines_q, font_q, incr_q, sow_q};
          OFS_PEEK:   rdata_d = {17'h0, peek_q, text_mem[peek_q]};
          default:    rdata_d = '0;
        endcase
      end
    end
    if (wr_pend_q) begin
      case (wa_q)
        OFS_CTRL: accept_d = hwdata[0];
        OFS_PEEK: peek_d = hwdata[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q        <= ST_IDLE;
      tmr_q       <= '0;
      ac_q        <= AC_HOME;
      clr_idx_q   <= AC_HOME;
      shift_q     <= SHIFT_RST;
      dhr_q       <= '0;
      glyph_q     <= 1'b0;
      incr_q      <= 1'b1;
      sow_q       <= 1'b0;
      disp_q      <= 1'b0;
      cur_q       <= 1'b0;
      blink_q     <= 1'b0;
      width8_q    <= 1'b1;
      lines_q     <= 1'b0;
      font_q      <= 1'b0;
      low_phase_q <= 1'b0;
      hi_nib_q    <= '0;
      db_out_q    <= '0;
      oe_q        <= 1'b0;
      accept_q    <= 1'b1;
      peek_q      <= '0;
      wr_pend_q   <= 1'b0;
      wa_q        <= '0;
      rdata_q     <= '0;
    end else begin
      st_q        <= st_d;
      tmr_q       <= tmr_d;
      ac_q        <= ac_d;
      clr_idx_q   <= clr_idx_d;
      shift_q     <= shift_d;
      dhr_q       <= dhr_d;
      glyph_q     <= glyph_d;
      incr_q      <= incr_d;
      sow_q       <= sow_d;
      disp_q      <= disp_d;
      cur_q       <= cur_d;
      blink_q     <= blink_d;
      width8_q    <= width8_d;
      lines_q     <= lines_d;
      font_q      <= font_d;
      low_phase_q <= low_phase_d;
      hi_nib_q    <= hi_nib_d;
      db_out_q    <= db_out_d;
      oe_q        <= oe_d;
      accept_q    <= accept_d;
      peek_q      <= peek_d;
      wr_pend_q   <= wr_pend_d;
      wa_q        <= wa_d;
      rdata_q     <= rdata_d;
    end
  end

  always_ff @(posedge hclk) begin
    if (txt_we) text_mem[mem_addr] <= mem_data;
    if (glf_we) glyph_mem[mem_addr[5:0]] <= mem_data;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign db_out    = db_out_q;
  assign db_oe     = oe_q ? (width8_q ? OE_BYTE : OE_UPPER) : OE_NONE;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_clear_home;
    pop && op == OP_CLEAR |=> ac_q == AC_HOME && st_q == ST_CLEAR && clr_idx_q == AC_HOME;
  endproperty
  a_clear_home: assert property (p_clear_home) else $error("clear did not home counter");

  property p_clear_fill;
    st_q == ST_CLEAR |=> text_mem[$past(clr_idx_q)] == SPACE_CODE;
  endproperty
  a_clear_fill: assert property (p_clear_fill) else $error("clear left a non-space");

  property p_home;
    pop && op == OP_HOME |=> ac_q == AC_HOME && shift_q == SHIFT_RST && !glyph_q;
  endproperty
  a_home: assert property (p_home) else $error("home did not reset counter or shift");

  property p_entry;
    pop && op == OP_ENTRY |=> incr_q == $past(e_byte[F_ID]) && sow_q == $past(e_byte[F_SH])
                              && tmr_q == TIMER_W'(CYC_SHORT - 1);
  endproperty
  a_entry: assert property (p_entry) else $error("entry mode not latched");

  property p_func;
    pop && op == OP_FUNC |=> width8_q == $past(e_byte[F_DL]) && font_q == $past(e_byte[F_F]);
  endproperty
  a_func: assert property (p_func) else $error("function set not latched");

  property p_glyph_addr;
    pop && op == OP_GLYPH |=> glyph_q && ac_q == {1'b0, $past(e_byte[5:0])};
  endproperty
  a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address wrong");

  property p_busy_read;
    rise && !rs_s && rw_s && width8_q && accept_q |=> db_out_q == {$past(busy), $past(ac_q)} && db_oe == OE_BYTE;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy/address read wrong");

  property p_write_store;
    pop && op == OP_WR && !glyph_q |=> text_mem[$past(ac_q)] == $past(e_byte);
  endproperty
  a_write_store: assert property (p_write_store) else $error("data write lost");

  property p_step;
    pop && (op == OP_WR || op == OP_RD) |=> ac_q == ac_step($past(ac_q), $past(incr_q), $past(glyph_q));
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  property p_busy_hold;
    pop |=> busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  c_clear_done: cover property (st_q == ST_CLEAR ##1 st_q == ST_WAIT);
  c_four_bit:   cover property (fifo_in_valid && !width8_q);
  c_fifo_full:  cover property (!fifo_in_ready);
endmodule

// ### host_bus_model.sv
module host_bus_model (
  input  wire logic       hclk,            // bench clock
  output logic            register_select, // data vs instruction
  output logic            rw_sel,          // high reads
  output logic            strobe_en,       // enable strobe
  output logic [7:0]      db_in,           // resolved bus level
  input  wire logic [7:0] db_out,          // device drive value
  input  wire logic [7:0] db_oe            // device drive enables
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       drv_q;
  logic [7:0] val_q;
  logic       four_bit;

  // a released line shows the inverse, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      db_in[i] = db_oe[i] ? db_out[i] : (drv_q ? val_q[i] : ~val_q[i]);
    end
  end

  initial begin
    register_select = 1'b0;
    rw_sel = 1'b0;
    strobe_en = 1'b0;
    drv_q = 1'b0;
    val_q = 8'h00;
    four_bit = 1'b0;
  end

  task automatic phase(input logic rs, input logic rw, input logic [7:0] b, output logic [7:0] rd);
    @(posedge hclk);
    register_select <= rs;
    rw_sel <= rw;
    drv_q <= !rw;
    val_q <= b;
    repeat (2) @(posedge hclk);
    strobe_en <= 1'b1;
    repeat (6) @(posedge hclk);
    rd = db_in;
    strobe_en <= 1'b0;
    repeat (5) @(posedge hclk);
    drv_q <= 1'b0;
  endtask

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] b, output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four_bit) begin
      phase(rs, rw, {b[7:4], 4'h0}, hi);
      phase(rs, rw, {b[3:0], 4'h0}, lo);
      rd = {hi[7:4], lo[7:4]};
    end else begin
      phase(rs, rw, b, rd);
    end
  endtask

  task automatic wait_ready(output logic ok);
    logic [7:0] r;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, r);
      if (r[7] === 1'b0) begin
        ok = 1'b1;
        repeat (19) @(posedge hclk);
      end
    end
  endtask
endmodule

// ### lcd_instr_engine_tb_top.sv
module lcd_instr_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_engine_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdw;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        register_select, rw_sel, strobe_en, ok;
  logic [7:0]  db_in, db_out, db_oe, rb;
  int          num_errors, n_tests;

  assign hready = hreadyout;
  lcd_instr_engine #(.CLEAR_CYCLES(200)) lcd_instr_engine_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .register_select, .rw_sel,
    .strobe_en, .db_in, .db_out, .db_oe);
  host_bus_model host_bus_model_i (.hclk, .register_select, .rw_sel, .strobe_en, .db_in, .db_out,
    .db_oe);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rdw = hrdata;
    chk({31'h0, hresp}, 32'h0);
    if (n >= 50) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic ready;
    host_bus_model_i.wait_ready(ok);
    if (ok !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic pin(input logic rs, input logic [7:0] b);
    host_bus_model_i.xfer(rs, 1'b0, b, rb);
    ready();
  endtask

  task automatic ac_is(input logic [7:0] e);
    host_bus_model_i.xfer(1'b0, 1'b1, 8'h00, rb);
    chk({24'h0, rb}, {24'h0, e});
  endtask

  task automatic peek(input logic [6:0] idx, input logic [7:0] e);
    ahb(1'b1, OFS_PEEK, {25'h0, idx});
    ahb(1'b0, OFS_PEEK, 32'h0);
    chk({24'h0, rdw[7:0]}, {24'h0, e});
  endtask

  task automatic t_reset;
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(rdw, 32'h1);
    ahb(1'b0, OFS_MODE, 32'h0);
    chk(rdw, 32'h12);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rdw, 32'h0);
  endtask

  task automatic t_clear;
    pin(1'b0, 8'h85);
    pin(1'b1, 8'h77);
    ac_is(8'h06);
    peek(7'h05, 8'h77);
    pin(1'b0, 8'h01);
    peek(7'h05, 8'h20);
    ac_is(8'h00);
  endtask

  task automatic t_entry_shift;
    pin(1'b0, 8'h04);
    pin(1'b0, 8'ha0);
    pin(1'b1, 8'h31);
    ac_is(8'h1f);
    pin(1'b0, 8'h14);
    ac_is(8'h20);
    pin(1'b0, 8'h10);
    pin(1'b0, 8'h18);
    ac_is(8'h1f);
    ahb(1'b0, OFS_MODE, 32'h0);
    chk({25'h0, rdw[14:8]}, 32'h1);
    peek(7'h20, 8'h31);
    pin(1'b0, 8'h02);
    ac_is(8'h00);
    peek(7'h20, 8'h31);
    pin(1'b0, 8'h07);
    pin(1'b1, 8'h41);
    ahb(1'b0, OFS_MODE, 32'h0);
    chk(rdw, 32'h113);
  endtask

  task automatic t_disp;
    logic [7:0] codes [2] = '{8'h0f, 8'h0a};
    for (int i = 0; i < 2; i++) begin
      pin(1'b0, codes[i]);
      ahb(1'b0, OFS_MODE, 32'h0);
      chk({29'h0, rdw[7:5]}, {29'h0, codes[i][2:0]});
    end
  endtask

  task automatic t_glyph;
    pin(1'b0, 8'h45);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rdw, 32'h105);
    pin(1'b1, 8'h1f);
    ac_is(8'h06);
    pin(1'b0, 8'h45);
    host_bus_model_i.xfer(1'b1, 1'b1, 8'h00, rb);
    ready();
    chk({24'h0, rb}, 32'h1f);
    ac_is(8'h06);
    pin(1'b0, 8'h80);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rdw, 32'h0);
  endtask

  task automatic t_nibble;
    host_bus_model_i.xfer(1'b0, 1'b0, 8'h28, rb);
    // width flips at execution, so the busy poll must already use nibbles
    host_bus_model_i.four_bit = 1'b1;
    ready();
    ahb(1'b0, OFS_MODE, 32'h0);
    chk({29'h0, rdw[4:2]}, 32'h2);
    pin(1'b0, 8'h90);
    pin(1'b1, 8'h5a);
    peek(7'h10, 8'h5a);
    ac_is(8'h11);
    pin(1'b0, 8'h90);
    host_bus_model_i.xfer(1'b1, 1'b1, 8'h00, rb);
    ready();
    chk({24'h0, rb}, 32'h5a);
    host_bus_model_i.xfer(1'b0, 1'b0, 8'h3c, rb);
    host_bus_model_i.four_bit = 1'b0;
    ready();
    ahb(1'b0, OFS_MODE, 32'h0);
    chk({29'h0, rdw[4:2]}, 32'h7);
  endtask

  // burst without polling on purpose: fills the queue until it drops
  task automatic t_fifo;
    pin(1'b0, 8'h80);
    for (int i = 0; i < 10; i++) begin
      host_bus_model_i.xfer(1'b1, 1'b0, 8'h60 + 8'(i), rb);
    end
    host_bus_model_i.xfer(1'b0, 1'b1, 8'h00, rb);
    chk({31'h0, rb[7]}, 32'h1);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rdw[10]}, 32'h1);
    ready();
    ac_is(8'h09);
    peek(7'h08, 8'h68);
    peek(7'h09, 8'h20);
  endtask

  // strobes are ignored while pin input is switched off
  task automatic t_ctrl;
    ahb(1'b1, OFS_CTRL, 32'h0);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(rdw, 32'h0);
    host_bus_model_i.xfer(1'b0, 1'b0, 8'hb3, rb);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rdw, 32'h9);
    ahb(1'b1, OFS_CTRL, 32'h1);
    ac_is(8'h09);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_clear();
    t_entry_shift();
    t_disp();
    t_glyph();
    t_nibble();
    t_fifo();
    t_ctrl();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    wrap_up();
  end
endmodule
